//--- logic/pmr_defs.svh
// pmr_defs.svh: offsets, field positions, frame sizes and the revision value
// assumes inclusion by both link ends and by the bench
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH
// device word store: frame word index doubles as storage index
`define PMR_IX_STATE 6'd2
`define PMR_IX_PSR   6'd3
`define PMR_IX_CRP   6'd4
`define PMR_IX_SRP   6'd8
`define PMR_IX_CAL   6'd12
`define PMR_IX_VAL   6'd13
`define PMR_IX_SCC   6'd14
`define PMR_IX_BAD   6'd22
`define PMR_IX_BAC   6'd30
`define PMR_IX_TC    6'd38
`define PMR_IX_DRP   6'd40
`define PMR_IX_AC    6'd44
`define PMR_IX_CACHE_STATUS_REG  6'd45
`define PMR_WORDS    46
`define PMR_NUM_BP   8
`define PMR_BAC_EN   0
// frame sizes in bytes, low byte of the format word
`define PMR_SZ_IDLE  8'h24
`define PMR_SZ_MID   8'h2c
`define PMR_SZ_BP    8'h4c
// revision in the format word high byte, arbitrary value
`define PMR_REV      8'h5a
// host register map, byte addresses on wishbone
`define PMR_A_CTRL   9'h000
`define PMR_A_EXT    9'h004
`define PMR_A_EA     9'h008
`define PMR_BUF_BIT  8
`define PMR_BUF_WORDS 48
// host control and status bits
`define PMR_C_START  0
`define PMR_C_SUP    3
`define PMR_S_BUSY   0
`define PMR_S_TRAP   1
`define PMR_S_ILL    2
`define PMR_S_FEXC   3
`endif

//--- logic/pmr_dev.sv
// pmr_dev.sv: unit end, register-move decode and state frame save/restore
// assumes the host end shares clk_i and always takes d2h words
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "pmr_defs.svh"
module pmr_dev
   import pmr_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   pmr_link_if.dev          lnk,
   input  wire logic [15:0] cache_status_i,
   output logic [31:0]      tc_o,
   output logic             bp_enabled_o,
   output logic [1:0]       pending_o
);
   typedef enum logic [1:0] {ST_IDLE, ST_IN, ST_OUT, ST_FMT} pmr_dst_e;

   logic [15:0] mem_reg [0:`PMR_WORDS-1];
   pmr_dst_e    st_reg;
   logic [5:0]  ptr_reg;
   logic [5:0]  last_reg;
   logic [7:0]  size_reg;
   logic        save_reg;
   logic        rest_reg;
   logic        byte_reg;
   logic        resp_valid_reg;
   pmr_resp_e   resp_code_reg;
   logic [5:0]  resp_len_reg;
   logic        d2h_valid_reg;
   logic [15:0] d2h_data_reg;
   logic        bp_en_reg;
   logic [2:0]  psel;
   logic [2:0]  mode;
   logic [2:0]  ereg;
   logic        dir;
   logic        regdir;
   logic        sel_ok;
   logic        is_root;
   logic        is_byte;
   logic        ea_in_ok;
   logic        ea_out_ok;
   logic        mv_ok;
   logic        rst_ea_ok;
   logic        bp_any;
   logic        fmt_ok;
   logic        fmt_null;
   logic        in_last;
   logic [5:0]  base;
   logic [5:0]  cnt;
   logic [5:0]  fmt_words;
   logic [7:0]  fsize;
   logic [7:0]  save_size;

   // command field split
   assign psel   = lnk.cmd_ext[12:10];
   assign dir    = lnk.cmd_ext[9];
   assign mode   = lnk.ea_mode;
   assign ereg   = lnk.ea_reg;
   assign regdir = (mode == 3'h0) || (mode == 3'h1);

   // register select decode: storage index, word count, width class
   always_comb begin
      base    = `PMR_IX_TC;
      cnt     = 6'd1;
      is_root = 1'b0;
      is_byte = 1'b0;
      sel_ok  = 1'b0;
      if (lnk.cmd_ext[15:13] == 3'h2) begin
         sel_ok = 1'b1;
         case (psel)
            3'h0: begin
               base = `PMR_IX_TC;
               cnt  = 6'd2;
            end
            3'h1: begin
               base    = `PMR_IX_DRP;
               cnt     = 6'd4;
               is_root = 1'b1;
            end
            3'h2: begin
               base    = `PMR_IX_SRP;
               cnt     = 6'd4;
               is_root = 1'b1;
            end
            3'h3: begin
               base    = `PMR_IX_CRP;
               cnt     = 6'd4;
               is_root = 1'b1;
            end
            3'h4: begin
               base    = `PMR_IX_CAL;
               is_byte = 1'b1;
            end
            3'h5: begin
               base    = `PMR_IX_VAL;
               is_byte = 1'b1;
            end
            3'h6: begin
               base    = `PMR_IX_SCC;
               is_byte = 1'b1;
            end
            default: begin
               base = `PMR_IX_AC;
            end
         endcase
      end else if (lnk.cmd_ext[15:13] == 3'h3) begin
         if (psel[2]) begin
            sel_ok = !psel[1];
            base   = (psel[0] ? `PMR_IX_BAC : `PMR_IX_BAD) + {3'h0, lnk.cmd_ext[4:2]};
         end else begin
            sel_ok = !psel[1] && (!psel[0] || dir);
            base   = psel[0] ? `PMR_IX_CACHE_STATUS_REG : `PMR_IX_PSR;
         end
      end
   end

   // addressing mode checks per direction and per command
   assign ea_in_ok  = (mode != 3'h7) || (ereg <= 3'h4);
   assign ea_out_ok = (mode != 3'h7) || (ereg <= 3'h1);
   assign mv_ok     = sel_ok && !(is_root && regdir) && (dir ? ea_out_ok : ea_in_ok);
   assign rst_ea_ok = (mode == 3'h2) || (mode == 3'h3) || (mode == 3'h5) || (mode == 3'h6) ||
                      ((mode == 3'h7) && (ereg <= 3'h3));

   // format word check and frame length in words
   assign fsize     = lnk.h2d_data[7:0];
   assign fmt_null  = (lnk.h2d_data == 16'h0000);
   assign fmt_ok    = fmt_null || ((lnk.h2d_data[15:8] == `PMR_REV) && ((fsize == `PMR_SZ_IDLE) ||
                      (fsize == `PMR_SZ_MID) || (fsize == `PMR_SZ_BP)));
   assign fmt_words = fmt_null ? 6'd2 : fsize[6:1];
   assign in_last   = (st_reg == ST_IN) && lnk.h2d_valid && (ptr_reg == last_reg);

   // any breakpoint enabled, and the save size it implies
   always_comb begin
      bp_any = 1'b0;
      for (int i = 0; i < `PMR_NUM_BP; i++) begin
         bp_any = bp_any | mem_reg[`PMR_IX_BAC + 6'(i)][`PMR_BAC_EN];
      end
   end
   assign save_size = bp_any ? `PMR_SZ_BP :
                      ((mem_reg[`PMR_IX_STATE][1:0] != 2'h0) ? `PMR_SZ_MID : `PMR_SZ_IDLE);

   // sequencer: command accept, operand streaming, responses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg         <= ST_IDLE;
         ptr_reg        <= 6'd0;
         last_reg       <= 6'd0;
         size_reg       <= 8'h00;
         save_reg       <= 1'b0;
         rest_reg       <= 1'b0;
         byte_reg       <= 1'b0;
         resp_valid_reg <= 1'b0;
         resp_code_reg  <= PMR_RSP_GO;
         resp_len_reg   <= 6'd0;
         d2h_valid_reg  <= 1'b0;
         d2h_data_reg   <= 16'h0000;
      end else begin
         resp_valid_reg <= 1'b0;
         d2h_valid_reg  <= 1'b0;
         if (lnk.cmd_valid && (lnk.cmd_op == PMR_OP_RESTORE)) begin
            resp_valid_reg <= !rst_ea_ok;
            resp_code_reg  <= PMR_RSP_ILLEGAL;
            st_reg         <= rst_ea_ok ? ST_FMT : ST_IDLE;
         end else if (lnk.cmd_valid && (lnk.cmd_op == PMR_OP_SAVE)) begin
            st_reg         <= ST_OUT;
            save_reg       <= 1'b1;
            rest_reg       <= 1'b0;
            size_reg       <= save_size;
            ptr_reg        <= 6'd0;
            last_reg       <= save_size[6:1] - 6'd1;
            resp_valid_reg <= 1'b1;
            resp_code_reg  <= PMR_RSP_GO;
            resp_len_reg   <= save_size[6:1];
         end else begin
            case (st_reg)
               ST_IDLE: begin
                  if (lnk.cmd_valid && (lnk.cmd_op == PMR_OP_MOVE)) begin
                     resp_valid_reg <= 1'b1;
                     resp_code_reg  <= mv_ok ? PMR_RSP_GO : PMR_RSP_ILLEGAL;
                     resp_len_reg   <= cnt;
                     if (mv_ok) begin
                        st_reg   <= dir ? ST_OUT : ST_IN;
                        save_reg <= 1'b0;
                        rest_reg <= 1'b0;
                        byte_reg <= is_byte;
                        ptr_reg  <= base;
                        last_reg <= base + cnt - 6'd1;
                     end
                  end
               end
               ST_FMT: begin
                  if (lnk.h2d_valid) begin
                     resp_valid_reg <= 1'b1;
                     resp_code_reg  <= fmt_ok ? PMR_RSP_GO : PMR_RSP_FORMAT;
                     resp_len_reg   <= fmt_words - 6'd1;
                     st_reg         <= fmt_ok ? ST_IN : ST_IDLE;
                     rest_reg       <= 1'b1;
                     byte_reg       <= 1'b0;
                     size_reg       <= fsize;
                     ptr_reg        <= 6'd1;
                     last_reg       <= fmt_words - 6'd1;
                  end
               end
               ST_IN: begin
                  if (lnk.h2d_valid) begin
                     ptr_reg <= ptr_reg + 6'd1;
                     if (ptr_reg == last_reg) begin
                        st_reg         <= ST_IDLE;
                        resp_valid_reg <= 1'b1;
                        resp_code_reg  <= PMR_RSP_DONE;
                     end
                  end
               end
               ST_OUT: begin
                  d2h_valid_reg <= 1'b1;
                  if (save_reg && (ptr_reg == 6'd0)) begin
                     d2h_data_reg <= {`PMR_REV, size_reg};
                  end else if (save_reg && (ptr_reg == 6'd1)) begin
                     d2h_data_reg <= 16'h0000;
                  end else begin
                     d2h_data_reg <= mem_reg[ptr_reg];
                  end
                  ptr_reg <= ptr_reg + 6'd1;
                  if (ptr_reg == last_reg) begin
                     st_reg         <= ST_IDLE;
                     resp_valid_reg <= 1'b1;
                     resp_code_reg  <= PMR_RSP_DONE;
                  end
               end
               default: begin
                  st_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // word store: operand writes, restore fix-ups, cache status mirror
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < `PMR_WORDS; i++) begin
            mem_reg[i] <= 16'h0000;
         end
      end else begin
         if ((st_reg == ST_IN) && lnk.h2d_valid) begin
            mem_reg[ptr_reg] <= byte_reg ? {8'h00, lnk.h2d_data[7:0]} : lnk.h2d_data;
         end
         if ((st_reg == ST_FMT) && lnk.h2d_valid && fmt_ok && !fmt_null && (fsize != `PMR_SZ_BP)) begin
            for (int i = 0; i < `PMR_NUM_BP; i++) begin
               mem_reg[`PMR_IX_BAC + 6'(i)][`PMR_BAC_EN] <= 1'b0;
            end
         end
         if (in_last && rest_reg) begin
            if (size_reg == 8'h00) begin
               mem_reg[`PMR_IX_STATE] <= 16'h0000;
            end else if (size_reg != `PMR_SZ_BP) begin
               mem_reg[`PMR_IX_STATE][1] <= (size_reg == `PMR_SZ_MID);
            end
         end
         if ((st_reg == ST_OUT) && save_reg && (ptr_reg == last_reg)) begin
            mem_reg[`PMR_IX_STATE] <= 16'h0000;
         end
         mem_reg[`PMR_IX_CACHE_STATUS_REG] <= cache_status_i;
      end
   end

   // registered view of breakpoint enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bp_en_reg <= 1'b0;
      end else begin
         bp_en_reg <= bp_any;
      end
   end

   // link and user outputs straight from flops
   assign lnk.resp_valid = resp_valid_reg;
   assign lnk.resp_code  = resp_code_reg;
   assign lnk.resp_len   = resp_len_reg;
   assign lnk.d2h_valid  = d2h_valid_reg;
   assign lnk.d2h_data   = d2h_data_reg;
   assign tc_o           = {mem_reg[`PMR_IX_TC], mem_reg[`PMR_IX_TC + 6'd1]};
   assign bp_enabled_o   = bp_en_reg;
   assign pending_o      = mem_reg[`PMR_IX_STATE][1:0];
endmodule

//--- logic/pmr_host.sv
// pmr_host.sv: main processor end, issues commands and moves operands
// assumes a classic wishbone master on clk_i and the unit end on the link
`timescale 1ns/1ps
`include "pmr_defs.svh"
module pmr_host
   import pmr_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [8:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   pmr_link_if.host         lnk,
   output logic             busy_o
);
   typedef enum logic [2:0] {H_IDLE, H_FMT, H_WAIT, H_SEND, H_RECV} pmr_hst_e;

   logic [15:0] buf_reg [0:`PMR_BUF_WORDS-1];
   pmr_hst_e    st_reg;
   pmr_op_e     op_reg;
   logic [15:0] ext_reg;
   logic [5:0]  ea_reg;
   logic [5:0]  idx_reg;
   logic [5:0]  rem_reg;
   logic        trap_reg;
   logic        ill_reg;
   logic        fexc_reg;
   logic        ack_reg;
   logic [31:0] rdat_reg;
   logic        cmd_valid_reg;
   logic        h2d_valid_reg;
   logic [15:0] h2d_data_reg;
   logic        wb_req;
   logic        wb_wr;
   logic        start;
   logic        ea_ok;
   pmr_op_e     new_op;

   // bus request decode; configuration writes only while idle
   assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wb_wr  = wb_cyc_i && wb_stb_i && ack_reg && wb_we_i && (st_reg == H_IDLE); // lands at the ack edge
   assign new_op = pmr_op_e'(wb_dat_i[2:1]);
   assign start  = wb_wr && (wb_adr_i == `PMR_A_CTRL) && wb_sel_i[0] && wb_dat_i[`PMR_C_START];
   assign ea_ok  = (ea_reg[5:3] == 3'h2) || (ea_reg[5:3] == 3'h3) || (ea_reg[5:3] == 3'h5) ||
                   (ea_reg[5:3] == 3'h6) || ((ea_reg[5:3] == 3'h7) && (ea_reg[2:0] <= 3'h3));

   // wishbone answer one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end else begin
         ack_reg  <= wb_req;
         rdat_reg <= 32'h0000_0000;
         if (wb_adr_i[`PMR_BUF_BIT] && (wb_adr_i[7:2] < 6'(`PMR_BUF_WORDS))) begin
            rdat_reg <= {16'h0000, buf_reg[wb_adr_i[7:2]]};
         end else if (wb_adr_i == `PMR_A_CTRL) begin
            rdat_reg <= {22'h0, idx_reg, fexc_reg, ill_reg, trap_reg, (st_reg != H_IDLE)};
         end else if (wb_adr_i == `PMR_A_EXT) begin
            rdat_reg <= {16'h0000, ext_reg};
         end else if (wb_adr_i == `PMR_A_EA) begin
            rdat_reg <= {26'h0, ea_reg};
         end
      end
   end

   // command word and operand address registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_reg <= 16'h0000;
         ea_reg  <= 6'h00;
      end else begin
         if (wb_wr && (wb_adr_i == `PMR_A_EXT) && wb_sel_i[0]) ext_reg[7:0] <= wb_dat_i[7:0];
         if (wb_wr && (wb_adr_i == `PMR_A_EXT) && wb_sel_i[1]) ext_reg[15:8] <= wb_dat_i[15:8];
         if (wb_wr && (wb_adr_i == `PMR_A_EA) && wb_sel_i[0]) ea_reg <= wb_dat_i[5:0];
      end
   end

   // operand buffer: software writes, frame and register reads fill it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < `PMR_BUF_WORDS; i++) begin
            buf_reg[i] <= 16'h0000;
         end
      end else if (wb_wr && wb_adr_i[`PMR_BUF_BIT] && (wb_adr_i[7:2] < 6'(`PMR_BUF_WORDS))) begin
         if (wb_sel_i[0]) buf_reg[wb_adr_i[7:2]][7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1]) buf_reg[wb_adr_i[7:2]][15:8] <= wb_dat_i[15:8];
      end else if ((st_reg == H_RECV) && lnk.d2h_valid) begin
         buf_reg[idx_reg] <= lnk.d2h_data;
      end
   end

   // command sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg        <= H_IDLE;
         op_reg        <= PMR_OP_MOVE;
         idx_reg       <= 6'd0;
         rem_reg       <= 6'd0;
         trap_reg      <= 1'b0;
         ill_reg       <= 1'b0;
         fexc_reg      <= 1'b0;
         cmd_valid_reg <= 1'b0;
         h2d_valid_reg <= 1'b0;
         h2d_data_reg  <= 16'h0000;
      end else begin
         cmd_valid_reg <= 1'b0;
         h2d_valid_reg <= 1'b0;
         case (st_reg)
            H_IDLE: begin
               if (start) begin
                  op_reg   <= new_op;
                  idx_reg  <= 6'd0;
                  trap_reg <= 1'b0;
                  ill_reg  <= 1'b0;
                  fexc_reg <= 1'b0;
                  if ((new_op != PMR_OP_MOVE) && !wb_dat_i[`PMR_C_SUP]) begin
                     trap_reg <= 1'b1;
                  end else if ((new_op == PMR_OP_RESTORE) && !ea_ok) begin
                     ill_reg <= 1'b1;
                  end else begin
                     cmd_valid_reg <= 1'b1;
                     st_reg        <= (new_op == PMR_OP_RESTORE) ? H_FMT : H_WAIT;
                  end
               end
            end
            H_FMT: begin
               h2d_valid_reg <= 1'b1;
               h2d_data_reg  <= buf_reg[0];
               st_reg        <= H_WAIT;
            end
            H_WAIT: begin
               if (lnk.resp_valid) begin
                  case (lnk.resp_code)
                     PMR_RSP_GO: begin
                        idx_reg <= (op_reg == PMR_OP_RESTORE) ? 6'd1 : 6'd0;
                        rem_reg <= lnk.resp_len;
                        st_reg  <= ((op_reg == PMR_OP_SAVE) || ((op_reg == PMR_OP_MOVE) && ext_reg[9])) ?
                                   H_RECV : H_SEND;
                     end
                     PMR_RSP_ILLEGAL: begin
                        ill_reg <= 1'b1;
                        st_reg  <= H_IDLE;
                     end
                     PMR_RSP_FORMAT: begin
                        fexc_reg <= 1'b1;
                        st_reg   <= H_IDLE;
                     end
                     default: begin
                        st_reg <= H_IDLE;
                     end
                  endcase
               end
            end
            H_SEND: begin
               h2d_valid_reg <= 1'b1;
               h2d_data_reg  <= buf_reg[idx_reg];
               idx_reg       <= idx_reg + 6'd1;
               rem_reg       <= rem_reg - 6'd1;
               if (rem_reg == 6'd1) st_reg <= H_WAIT;
            end
            H_RECV: begin
               if (lnk.d2h_valid) idx_reg <= idx_reg + 6'd1;
               if (lnk.resp_valid) st_reg <= H_IDLE;
            end
            default: begin
               st_reg <= H_IDLE;
            end
         endcase
      end
   end

   // link and bus outputs from flops
   assign lnk.cmd_valid = cmd_valid_reg;
   assign lnk.cmd_op    = op_reg;
   assign lnk.cmd_ext   = ext_reg;
   assign lnk.ea_mode   = ea_reg[5:3];
   assign lnk.ea_reg    = ea_reg[2:0];
   assign lnk.h2d_valid = h2d_valid_reg;
   assign lnk.h2d_data  = h2d_data_reg;
   assign wb_ack_o      = ack_reg;
   assign wb_dat_o      = rdat_reg;
   assign busy_o        = (st_reg != H_IDLE);
endmodule

//--- logic/pmr_link_if.sv
// pmr_link_if.sv: command, operand and response link between host and unit
// assumes both ends run on one clock
`timescale 1ns/1ps
interface pmr_link_if;
   import pmr_pkg::*;
   logic        cmd_valid;
   pmr_op_e     cmd_op;
   logic [15:0] cmd_ext;
   logic [2:0]  ea_mode;
   logic [2:0]  ea_reg;
   logic        h2d_valid;
   logic [15:0] h2d_data;
   logic        resp_valid;
   pmr_resp_e   resp_code;
   logic [5:0]  resp_len;
   logic        d2h_valid;
   logic [15:0] d2h_data;
   modport dev  (input cmd_valid, cmd_op, cmd_ext, ea_mode, ea_reg, h2d_valid, h2d_data,
                 output resp_valid, resp_code, resp_len, d2h_valid, d2h_data);
   modport host (output cmd_valid, cmd_op, cmd_ext, ea_mode, ea_reg, h2d_valid, h2d_data,
                 input resp_valid, resp_code, resp_len, d2h_valid, d2h_data);
endinterface

//--- logic/pmr_pkg.sv
// pmr_pkg.sv: types shared by both link ends
// assumes nothing beyond the compiler
package pmr_pkg;
   typedef enum logic [1:0] {PMR_OP_MOVE, PMR_OP_SAVE, PMR_OP_RESTORE} pmr_op_e;
   typedef enum logic [1:0] {PMR_RSP_GO, PMR_RSP_ILLEGAL, PMR_RSP_FORMAT, PMR_RSP_DONE} pmr_resp_e;
endpackage

//--- verif/pmr_link_monitor.sv
// pmr_link_monitor.sv: protocol checks on the link between host and unit ends
// assumes it watches the single link instance of the bench
`timescale 1ns/1ps
`include "pmr_defs.svh"
module pmr_link_monitor
   import pmr_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cmd_valid,
   input wire pmr_op_e     cmd_op,
   input wire logic        h2d_valid,
   input wire logic [15:0] h2d_data,
   input wire logic        resp_valid,
   input wire pmr_resp_e   resp_code,
   input wire logic [5:0]  resp_len,
   input wire logic        d2h_valid,
   input wire logic [15:0] d2h_data
);
   // command and answer shorthands
   wire rs = cmd_valid && cmd_op == PMR_OP_RESTORE;
   wire sv = cmd_valid && cmd_op == PMR_OP_SAVE;
   wire go = resp_valid && resp_code == PMR_RSP_GO;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // answers, frame sizes and format word handling
   a_move_answer: assert property (
      cmd_valid && cmd_op == PMR_OP_MOVE |=> resp_valid && resp_code inside {PMR_RSP_GO, PMR_RSP_ILLEGAL})
      else $error("move not answered");
   a_save_size: assert property (
      sv |=> go && resp_len inside {6'd18, 6'd22, 6'd38} ##1 d2h_valid
      && d2h_data == {`PMR_REV, 1'b0, $past(resp_len), 1'b0}) else $error("save frame size");
   a_save_burst: assert property (
      sv |=> ##1 d2h_valid [*8]) else $error("save words not back to back");
   a_restore_quiet: assert property (
      rs |=> !resp_valid || resp_code == PMR_RSP_ILLEGAL) else $error("restore answered early");
   a_format_bad: assert property (
      rs ##1 h2d_valid && h2d_data != 16'h0 && h2d_data[15:8] != `PMR_REV
      |=> resp_valid && resp_code == PMR_RSP_FORMAT) else $error("bad format accepted");
   a_format_good: assert property (
      rs ##1 h2d_valid && h2d_data[15:8] == `PMR_REV && h2d_data[7:0] inside {`PMR_SZ_IDLE, `PMR_SZ_MID, `PMR_SZ_BP}
      |=> go && resp_len == $past(h2d_data[6:1]) - 6'd1) else $error("good format length");
   a_null_frame: assert property (
      rs ##1 h2d_valid && h2d_data == 16'h0 |=> go && resp_len == 6'd1) else $error("null frame length");
   a_done_cause: assert property (
      resp_valid && resp_code == PMR_RSP_DONE |-> d2h_valid || $past(h2d_valid)) else $error("done without word");
endmodule

//--- verif/testbench.sv
// testbench.sv: drives the host end over wishbone, unit end on the link
// assumes both ends and the link monitor are compiled first
`timescale 1ns/1ps
`include "pmr_defs.svh"
module testbench;
   import pmr_pkg::*;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, busy, bpen;
   logic [8:0]  adr = 0;
   logic [31:0] dat = 0, rd, tc, v, q;
   logic [15:0] cs = 0, fr [22];
   logic [1:0]  pend;
   logic [28:0] tb [8];
   int          mismatches = 0, samples_checked = 0, i;
   pmr_link_if  lnk ();
   pmr_host i_pmr_host (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .lnk(lnk.host), .busy_o(busy));
   pmr_dev i_pmr_dev (.clk_i, .rst_i, .lnk(lnk.dev), .cache_status_i(cs), .tc_o(tc), .bp_enabled_o(bpen),
      .pending_o(pend));
   pmr_link_monitor i_pmr_link_monitor (.clk_i, .rst_i, .cmd_valid(lnk.cmd_valid), .cmd_op(lnk.cmd_op),
      .h2d_valid(lnk.h2d_valid), .h2d_data(lnk.h2d_data), .resp_valid(lnk.resp_valid),
      .resp_code(lnk.resp_code), .resp_len(lnk.resp_len), .d2h_valid(lnk.d2h_valid), .d2h_data(lnk.d2h_data));
   // 20 MHz clock
   initial forever #25 clk_i = ~clk_i;
   function automatic logic [15:0] fw(input logic [7:0] sz);
      return {`PMR_REV, sz};
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, s);
      samples_checked++;
      if (s !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one classic cycle, held until ack, data taken at the ack edge
   task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 40);
      q = rd;
      {cyc, stb} <= 2'b00;
      if (n >= 40) begin
         mismatches++;
         $display("Error bus ack expected 1 seen %b", ack);
         summarize();
      end
   endtask
   task automatic wbuf(input int k, input logic [15:0] w);
      wb(1, 9'h100 + 9'(4 * k), {16'h0, w});
   endtask
   task automatic rbuf(input int k);
      wb(0, 9'h100 + 9'(4 * k), 0);
   endtask
   // issue one command and poll busy; status left in q
   task automatic run(input logic [3:0] c, input logic [15:0] x, input logic [5:0] ea);
      int n;
      n = 0;
      wb(1, `PMR_A_EXT, {16'h0, x});
      wb(1, `PMR_A_EA, {26'h0, ea});
      wb(1, `PMR_A_CTRL, {28'h0, c});
      do begin
         wb(0, `PMR_A_CTRL, 0);
         n++;
      end while (q[0] !== 1'b0 && n < 60);
      if (n >= 60) begin
         mismatches++;
         $display("Error busy expected 0 seen %b", q[0]);
         summarize();
      end
   endtask
   // scenarios: move, refusals, restore/save round trip, breakpoints
   initial begin
      tb = '{{4'h9, 16'h4c00, 6'h00, 3'h2}, {4'h9, 16'h4e00, 6'h08, 3'h2}, {4'h9, 16'h4200, 6'h3c, 3'h2},
             {4'h9, 16'h6400, 6'h10, 3'h2}, {4'h9, 16'h6600, 6'h10, 3'h0}, {4'h9, 16'h4000, 6'h3c, 3'h0},
             {4'hd, 16'h0, 6'h20, 3'h2}, {4'h3, 16'h0, 6'h10, 3'h1}};
      void'($urandom(71));
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      cs    <= 16'($urandom);
      v = $urandom;
      wbuf(0, v[31:16]);
      wbuf(1, v[15:0]);
      run(4'h9, 16'h4000, 6'h00);
      chk("move flags", 0, q[3:1]);
      chk("tc", v, tc);
      for (i = 0; i < 8; i++) begin
         run(tb[i][28:25], tb[i][24:9], tb[i][8:3]);
         chk("refusal flags", tb[i][2:0], q[3:1]);
      end
      // cache status read out lands in word 0, immediate move then loads it into tc
      chk("tc from cache status", {cs, v[15:0]}, tc);
      for (i = 0; i < 22; i++) begin
         fr[i] = (i == 0) ? fw(`PMR_SZ_MID) : (i < 3) ? 16'h0 : 16'($urandom);
         wbuf(i, fr[i]);
      end
      run(4'hd, 0, 6'h10);
      chk("restore flags", 0, q[3:1]);
      chk("pending", 2'h2, pend);
      wbuf(0, 16'h0fac);
      run(4'hd, 0, 6'h18);
      chk("format flags", 3'h4, q[3:1]);
      chk("format pending", 2'h2, pend);
      wbuf(0, 16'h0);
      run(4'hd, 0, 6'h10);
      chk("null pending", 0, pend);
      run(4'hb, 0, 6'h10);
      rbuf(0);
      chk("idle format", fw(`PMR_SZ_IDLE), q);
      for (i = 3; i < 15; i++) begin
         rbuf(i);
         chk("saved word", fr[i], q);
      end
      chk("save pending", 0, pend);
      chk("save tc", {cs, v[15:0]}, tc);
      wbuf(0, 16'h1);
      run(4'h9, 16'h7400, 6'h00);
      chk("bp enabled", 1, bpen);
      run(4'hb, 0, 6'h10);
      rbuf(`PMR_IX_BAC);
      chk("bp control saved", 1, q);
      rbuf(0);
      chk("bp format", fw(`PMR_SZ_BP), q);
      // clear the breakpoint, then bring it back from the saved frame
      wbuf(0, 16'h0);
      run(4'h9, 16'h7400, 6'h00);
      chk("bp cleared", 0, bpen);
      wbuf(0, fw(`PMR_SZ_BP));
      wbuf(2, 16'h3);
      run(4'hd, 0, 6'h10);
      chk("bp restore pending", 2'h3, pend);
      chk("bp restored", 1, bpen);
      chk("host idle", 0, busy);
      summarize();
   end
endmodule
